//--- isp_port.sv
// Serial-bus slave port giving a host access to the internal register image,
// with standard/fast and high-speed settings.
// Assumes SCL and SDA arrive unsynchronised from pins; SDA is open drain outside.
//
// Function
// - Address with direction 1 makes the device return the addressed register.
// - All bytes of one read frame come from the same register, no increment.
// - In high-speed, repeated START and 7-bit address follow; device acknowledges.
// - High-speed persists over repeated STARTs and ends only on STOP.
// - After reset the port runs in fast mode, which serves standard traffic.
// - Master code sequence switches the input filters to high-speed.
// - Force bit set keeps the port permanently in high-speed, no master code.
// - Without a master code or the force bit set, the port stays in standard/fast mode.
// - High-speed mode supports bit rates up to 3.4 Mbit/s.
// - Port is slave only: never drives the clock, never arbitrates.
// - Slave address taken from pins once at reset release, then frozen.
// - Every data byte of a write frame goes to the same register.
// - Master not-acknowledging a read byte makes the device release the data line.
`timescale 1ns/10ps
`default_nettype none

module isp_port #(
  parameter int unsigned P_FS_FILT = isp_pkg::FS_FILT_CYC,
  parameter int unsigned P_HS_FILT = isp_pkg::HS_FILT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe_b,
  input wire logic i_address_scheme_select_pin,
  input wire logic [5:0] i_adr_pins,
  input wire logic i_force_fast_link_permanent,
  output logic o_high_speed_mode,
  output logic [6:0] o_dev_addr,
  output isp_pkg::isp_reg_req_t o_reg_req,
  output logic [7:0] o_reg_rdata
);

  // Filtered line levels: bit 0 is SCL, bit 1 is SDA
  logic [1:0] line_f;
  logic [1:0] line_p_q;
  logic [4:0] filt_lim;
  logic high_speed_mode;
  logic hs_q, hs_d;

  // Limit follows the active speed setting; HS window keeps 3.4 Mbit/s bits intact
  assign high_speed_mode = hs_q | i_force_fast_link_permanent;
  assign filt_lim = high_speed_mode ? 5'(P_HS_FILT) : 5'(P_FS_FILT);

  // Two-stage synchroniser then a stability filter per line
  genvar g;
  for (g = 0; g < 2; g++) begin : g_line
    logic s1_q, s2_q, flt_q;
    logic [4:0] cnt_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        flt_q <= 1'b1;
        cnt_q <= '0;
      end else begin
        s1_q <= (g == 0) ? i_scl : i_sda_i;
        s2_q <= s1_q;
        if (s2_q == flt_q) begin
          cnt_q <= '0;
        end else if (cnt_q >= filt_lim) begin
          flt_q <= s2_q;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
    assign line_f[g] = flt_q;
  end

  // Bus events from filtered levels
  logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;
  assign scl_f = line_f[0];
  assign sda_f = line_f[1];
  assign scl_rise = scl_f & ~line_p_q[0];
  assign scl_fall = ~scl_f & line_p_q[0];
  assign start_det = scl_f & line_p_q[0] & ~sda_f & line_p_q[1];
  assign stop_det = scl_f & line_p_q[0] & sda_f & ~line_p_q[1];

  // Address pins: synchronised, then caught once after reset release
  logic [6:0] pin_s1_q, pin_s2_q;
  logic [1:0] adr_cnt_q;
  logic adr_ok_q;
  logic [6:0] dev_addr_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      adr_cnt_q <= '0;
      adr_ok_q <= 1'b0;
      dev_addr_q <= '0;
    end else begin
      pin_s1_q <= {i_address_scheme_select_pin, i_adr_pins};
      pin_s2_q <= pin_s1_q;
      if (!adr_ok_q && adr_cnt_q == isp_pkg::ADDR_TAKE_CYC) begin
        adr_ok_q <= 1'b1;
        dev_addr_q <= pin_s2_q[6] ? {1'b0, pin_s2_q[5:0]} : {isp_pkg::FIXED_ADDR_HI, pin_s2_q[2:0]};
      end else if (!adr_ok_q) begin
        adr_cnt_q <= adr_cnt_q + 2'h1;
      end
    end
  end

  // Protocol state
  isp_pkg::isp_state_t state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic ack_q, ack_d, slot_q, slot_d, pend_q, pend_d, drv_q, drv_d;
  logic [5:0] reg_addr_q, reg_addr_d;
  isp_pkg::isp_reg_req_t req_d, req_q;
  logic [7:0] rdata;
  logic [7:0] byte_in;
  logic byte_done, mcode_hit, addr_hit;

  assign byte_in = {sh_q[6:0], sda_f};
  assign byte_done = scl_rise & ~ack_q & (bit_q == isp_pkg::BIT_LAST);
  assign mcode_hit = ~high_speed_mode & (byte_in[7:3] == isp_pkg::MCODE_PAT);
  assign addr_hit = adr_ok_q & (byte_in[7:1] == dev_addr_q);

  // Next-state decode; START and STOP override any bit in flight
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ack_d = ack_q;
    slot_d = slot_q;
    pend_d = pend_q;
    drv_d = drv_q;
    hs_d = hs_q;
    reg_addr_d = reg_addr_q;
    req_d = '{wr: 1'b0, rd: 1'b0, addr: reg_addr_q, wdata: byte_in};
    if (stop_det) begin
      state_d = isp_pkg::ST_IDLE;
      hs_d = 1'b0;
      ack_d = 1'b0;
      slot_d = 1'b0;
      drv_d = 1'b0;
    end else if (start_det) begin
      state_d = isp_pkg::ST_ADDR; // repeated START keeps hs_q
      bit_d = '0;
      ack_d = 1'b0;
      slot_d = 1'b0;
      drv_d = 1'b0;
    end else if (byte_done) begin
      ack_d = 1'b1;
      bit_d = '0;
      pend_d = 1'b0;
      unique case (state_q)
        isp_pkg::ST_ADDR: begin
          if (mcode_hit) begin
            state_d = isp_pkg::ST_MCODE;
          end else if (addr_hit) begin
            pend_d = 1'b1;
            state_d = byte_in[0] ? isp_pkg::ST_RD : isp_pkg::ST_REG;
            req_d.rd = byte_in[0];
          end else begin
            state_d = isp_pkg::ST_SKIP;
          end
        end
        isp_pkg::ST_REG: begin
          reg_addr_d = byte_in[5:0];
          pend_d = 1'b1;
          state_d = isp_pkg::ST_WR;
        end
        isp_pkg::ST_WR: begin
          req_d.wr = 1'b1;
          pend_d = 1'b1;
        end
        default: begin
          pend_d = 1'b0;
        end
      endcase
    end else if (scl_rise && !ack_q) begin
      sh_d = byte_in;
      bit_d = bit_q + 4'h1;
    end else if (scl_rise && slot_q) begin
      // Ninth clock high: sample the acknowledge slot
      if (state_q == isp_pkg::ST_MCODE && sda_f) begin
        hs_d = 1'b1;
      end else if (state_q == isp_pkg::ST_RD && !pend_q && sda_f) begin
        state_d = isp_pkg::ST_SKIP;
      end else if (state_q == isp_pkg::ST_RD && !pend_q) begin
        req_d.rd = 1'b1;
      end
    end else if (scl_fall && ack_q && !slot_q) begin
      slot_d = 1'b1;
      drv_d = pend_q;
    end else if (scl_fall && ack_q) begin
      // Slot ends: release, and a transmitter puts out its MSB
      ack_d = 1'b0;
      slot_d = 1'b0;
      pend_d = 1'b0;
      tx_d = rdata;
      drv_d = (state_q == isp_pkg::ST_RD) & ~rdata[7];
    end else if (scl_fall && state_q == isp_pkg::ST_RD && bit_q != 4'h0) begin
      tx_d = {tx_q[6:0], 1'b0};
      drv_d = ~tx_q[6];
    end
  end

  // Register stage for the protocol state
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= isp_pkg::ST_IDLE;
      bit_q <= '0;
      sh_q <= isp_pkg::BYTE_RST;
      tx_q <= isp_pkg::BYTE_RST;
      {ack_q, slot_q, pend_q, drv_q} <= 4'h0;
      hs_q <= 1'b0;
      reg_addr_q <= isp_pkg::REG_ADDR_RST;
      req_q <= '0;
      line_p_q <= 2'h3;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      {ack_q, slot_q, pend_q, drv_q} <= {ack_d, slot_d, pend_d, drv_d};
      hs_q <= hs_d;
      reg_addr_q <= reg_addr_d;
      req_q <= req_d;
      line_p_q <= line_f;
    end
  end

  isp_regmem #(
    .AW(6),
    .DW(8)
  ) u_regmem (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_wr(req_q.wr),
    .i_waddr(req_q.addr),
    .i_wdata(req_q.wdata),
    .i_raddr(reg_addr_q),
    .o_rdata(rdata)
  );

  // Open drain: only ever pulls low; no clock output exists at all
  assign o_sda_o = 1'b0;
  assign o_sda_oe_b = ~drv_q;
  assign o_high_speed_mode = high_speed_mode;
  assign o_dev_addr = dev_addr_q;
  assign o_reg_req = req_q;
  assign o_reg_rdata = rdata;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  mode_reset_a: assert property (!adr_ok_q |-> !hs_q) else $error("high-speed set right after reset");
  hs_entry_a: assert property (state_q == isp_pkg::ST_MCODE && slot_q && scl_rise && sda_f && !stop_det
    |=> hs_q) else $error("master code sequence did not enter high-speed");
  hs_keep_a: assert property (hs_q && start_det |=> hs_q && state_q == isp_pkg::ST_ADDR)
    else $error("repeated start left high-speed");
  hs_stop_a: assert property (stop_det && !i_force_fast_link_permanent |=> !o_high_speed_mode ##1 !hs_q)
    else $error("stop did not restore fast setting");
  force_hs_a: assert property (i_force_fast_link_permanent && stop_det |=> o_high_speed_mode
    && filt_lim == 5'(P_HS_FILT)) else $error("forced high-speed lost");
  wr_same_a: assert property (o_reg_req.wr |-> o_reg_req.addr == reg_addr_q && state_q == isp_pkg::ST_WR)
    else $error("write went to another register");
  rd_same_a: assert property (state_q == isp_pkg::ST_RD && $stable(state_q) |-> $stable(reg_addr_q))
    else $error("read address moved inside frame");
  addr_frozen_a: assert property (adr_ok_q |=> $stable(dev_addr_q) && adr_ok_q)
    else $error("slave address changed after reset");
  nack_release_a: assert property (state_q == isp_pkg::ST_RD && slot_q && !pend_q && scl_rise && sda_f
    && !stop_det && !start_det |=> state_q == isp_pkg::ST_SKIP ##1 o_sda_oe_b[*3])
    else $error("data line held after master nack");
  ack_own_a: assert property (state_q == isp_pkg::ST_ADDR && byte_done && addr_hit && !stop_det
    |=> pend_q && ack_q) else $error("own address not acknowledged");
  drive_low_a: assert property ($fell(o_sda_oe_b) |-> !scl_f)
    else $error("data line pulled while clock high");

  hs_session_c: cover property (hs_q ##[1:1000] start_det);
  read_frame_c: cover property (state_q == isp_pkg::ST_RD && o_reg_req.rd);
  write_frame_c: cover property (o_reg_req.wr ##[1:1000] o_reg_req.wr);
  master_nack_c: cover property (state_q == isp_pkg::ST_RD ##1 state_q == isp_pkg::ST_SKIP);

endmodule

`default_nettype wire

//--- isp_pkg.sv
// Constants, state codes and carrier types for the serial-bus slave register port.
// Assumes a 250 MHz system clock; all times below are turned into cycles here.
`default_nettype none

package isp_pkg;

  // System clock rate and spike suppression windows per speed setting
  localparam int unsigned SYS_CLK_MHZ = 250;
  localparam int unsigned FS_SPIKE_NS = 50;
  localparam int unsigned HS_SPIKE_NS = 10;
  // Longest spike that is swallowed: round down, never below one cycle
  localparam int unsigned FS_FILT_CYC = ((FS_SPIKE_NS * SYS_CLK_MHZ) / 1000 > 0) ?
                                        (FS_SPIKE_NS * SYS_CLK_MHZ) / 1000 : 1;
  localparam int unsigned HS_FILT_CYC = ((HS_SPIKE_NS * SYS_CLK_MHZ) / 1000 > 0) ?
                                        (HS_SPIKE_NS * SYS_CLK_MHZ) / 1000 : 1;
  // Highest bit rate served in high-speed mode, in kbit/s
  localparam int unsigned HS_MAX_KBPS = 3400;

  // Cycles after reset release before the synchronised address pins are taken
  localparam logic [1:0] ADDR_TAKE_CYC = 2'h2;
  // Fixed upper nibble of the slave address when the scheme pin is low
  localparam logic [3:0] FIXED_ADDR_HI = 4'h5;
  // Upper five bits of a master code byte
  localparam logic [4:0] MCODE_PAT = 5'h01;
  // Data bits in one byte, minus one
  localparam logic [3:0] BIT_LAST = 4'h7;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [5:0] REG_ADDR_RST = 6'h00;

  // Protocol states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_MCODE = 7'h04,
    ST_REG   = 7'h08,
    ST_WR    = 7'h10,
    ST_RD    = 7'h20,
    ST_SKIP  = 7'h40
  } isp_state_t;

  // Access towards the internal register space
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } isp_reg_req_t;

endpackage

`default_nettype wire

//--- isp_regmem.sv
// Register image reached through the serial port: one write port, registered read.
// Assumes writer and reader share the system clock.
`timescale 1ns/10ps
`default_nettype none

module isp_regmem #(
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);

  logic [DW-1:0] mem_q [2**AW];

  // Storage array has no reset, so it maps onto plain memory
  always_ff @(posedge i_sys_clk) begin
    if (i_wr) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // Read data comes out of a register; a write shows on the next read cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem_q[i_raddr];
    end
  end

endmodule

`default_nettype wire

//--- isp_bus_master.sv
// Bus master model for the serial link: drives the clock and the open-drain data line.
// Assumes the bench resolves the wired-AND data line and feeds it back on i_sda.
`timescale 1ns/10ps
`default_nettype none

module isp_bus_master (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_drv
);
  // Quarter of the 64 ns link period
  localparam int Q = 16;

  // Both lines released; the clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
  end

  // START, or repeated START when the clock is low; the gap lets a slave release its ack
  task automatic start_c();
    if (o_scl === 1'b0) begin
      #Q o_sda_drv = 1'b1;
      #(2*Q) o_scl = 1'b1;
    end
    #Q o_sda_drv = 1'b0;
    #Q o_scl = 1'b0;
  endtask

  // STOP: data rises while the clock is high
  task automatic stop_c();
    #Q o_sda_drv = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_drv = 1'b1;
    #Q;
  endtask

  // One clock pulse; data only changes while the clock is low
  task automatic bit_c(input logic b, output logic s);
    #Q o_sda_drv = b;
    #Q o_scl = 1'b1;
    #Q s = i_sda;
    #Q o_scl = 1'b0;
  endtask

  // Byte out, MSB first; ninth bit released so the receiver can answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], s);
    end
    bit_c(1'b1, s);
    ack = ~s;
  endtask

  // Byte in; a low ninth bit asks for more, a high one ends the read
  task automatic recv_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, b[i]);
    end
    bit_c(~mack, s);
  endtask
endmodule

`default_nettype wire

//--- isp_port_tb.sv
// Self-checking bench for the serial-bus slave register port.
// Assumes the port holds its register image inside; the bus master model sits on the link.
`timescale 1ns/10ps
`default_nettype none

module isp_port_tb;
  localparam logic [5:0] ADR = 6'h2a;
  localparam logic [6:0] DEV = 7'h2a;
  logic i_sys_clk, i_rst_b, scheme, force_hs, scl, sda_drv, o_sda_o, o_sda_oe_b, hs;
  logic [5:0] adr_pins;
  logic [6:0] o_dev_addr;
  logic [7:0] o_reg_rdata;
  isp_pkg::isp_reg_req_t o_reg_req;
  isp_pkg::isp_reg_req_t wr_log[$];
  int err_total, checked, rd_cnt;
  wire logic sda;

  // Wired-AND data line with pull-up: released means high
  assign sda = sda_drv & (o_sda_oe_b | o_sda_o);

  isp_port #(.P_FS_FILT(1), .P_HS_FILT(1)) isp_port_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda_i(sda), .o_sda_o(o_sda_o),
    .o_sda_oe_b(o_sda_oe_b), .i_address_scheme_select_pin(scheme), .i_adr_pins(adr_pins),
    .i_force_fast_link_permanent(force_hs), .o_high_speed_mode(hs), .o_dev_addr(o_dev_addr),
    .o_reg_req(o_reg_req), .o_reg_rdata(o_reg_rdata));

  isp_bus_master isp_bus_master_inst (.i_sda(sda), .o_scl(scl), .o_sda_drv(sda_drv));

  // 250 MHz system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // Log every write pulse and count read pulses towards the register image
  always @(posedge i_sys_clk) begin
    if (o_reg_req.wr === 1'b1) wr_log.push_back(o_reg_req);
    if (o_reg_req.rd === 1'b1) rd_cnt++;
  end

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // Send a byte and judge the slave's acknowledge
  task automatic tx(input logic [7:0] b, input logic ea);
    logic a;
    isp_bus_master_inst.send_byte(b, a);
    chk_bit(a, ea, "ack");
  endtask

  // Receive a byte and judge it
  task automatic rx(input logic mack, input logic [7:0] exp);
    logic [7:0] d;
    isp_bus_master_inst.recv_byte(mack, d);
    chk_byte(d, exp, "read data");
  endtask

  // Reset state and address catching; later pin changes must not move the address
  task automatic t_reset();
    chk_bit(hs, 1'b0, "fast after reset");
    chk_bit(o_sda_o, 1'b0, "open drain value");
    chk_byte({1'b0, o_dev_addr}, {1'b0, DEV}, "address");
    adr_pins = 6'h15;
    cyc(8);
    chk_byte({1'b0, o_dev_addr}, {1'b0, DEV}, "address frozen");
  endtask

  // Two data bytes in one frame both land on the same register
  task automatic t_write();
    isp_bus_master_inst.start_c();
    tx({DEV, 1'b0}, 1'b1);
    tx(8'h05, 1'b1);
    tx(8'ha5, 1'b1);
    tx(8'h3c, 1'b1);
    isp_bus_master_inst.stop_c();
    cyc(10);
    chk_byte(8'(wr_log.size()), 8'h02, "write count");
    chk_byte({2'h0, wr_log[0].addr}, 8'h05, "addr 1");
    chk_byte({2'h0, wr_log[1].addr}, 8'h05, "addr 2");
    chk_byte(wr_log[0].wdata, 8'ha5, "wdata 1");
    chk_byte(wr_log[1].wdata, 8'h3c, "wdata");
  endtask

  // Address-setting frame, then a separate read frame repeats one register
  task automatic t_read();
    int rd0;
    rd0 = rd_cnt;
    isp_bus_master_inst.start_c();
    tx({DEV, 1'b0}, 1'b1);
    tx(8'h05, 1'b1);
    isp_bus_master_inst.stop_c();
    isp_bus_master_inst.start_c();
    tx({DEV, 1'b1}, 1'b1);
    rx(1'b1, 8'h3c);
    rx(1'b0, 8'h3c);
    // Wait past the filtered clock fall so the slot end has been handled
    cyc(8);
    chk_bit(o_sda_oe_b, 1'b1, "released after nack");
    isp_bus_master_inst.stop_c();
    chk_byte(8'(wr_log.size()), 8'h02, "no data written");
    chk_byte(8'(rd_cnt - rd0), 8'h02, "read pulses");
    chk_byte(o_reg_rdata, 8'h3c, "image data");
  endtask

  // Scheme pin low: a second reset takes the fixed upper nibble plus three pins
  task automatic t_scheme();
    logic [6:0] dev2;
    dev2 = {isp_pkg::FIXED_ADDR_HI, adr_pins[2:0]};
    scheme = 1'b0;
    i_rst_b = 1'b0;
    cyc(3);
    i_rst_b = 1'b1;
    cyc(12);
    chk_byte({1'b0, o_dev_addr}, {1'b0, dev2}, "scheme address");
    chk_bit(hs, 1'b0, "fast after second reset");
    isp_bus_master_inst.start_c();
    tx({dev2, 1'b0}, 1'b1);
    tx(8'h05, 1'b1);
    isp_bus_master_inst.start_c();
    tx({dev2, 1'b1}, 1'b1);
    rx(1'b0, 8'h3c);
    isp_bus_master_inst.stop_c();
  endtask

  // Master code, chained transfers over repeated STARTs, STOP ends the session
  task automatic t_hs(input logic [7:0] code);
    isp_bus_master_inst.start_c();
    tx(code, 1'b0);
    cyc(2);
    chk_bit(hs, 1'b1, "hs entered");
    isp_bus_master_inst.start_c();
    tx({DEV, 1'b1}, 1'b1);
    rx(1'b0, 8'h3c);
    isp_bus_master_inst.start_c();
    chk_bit(hs, 1'b1, "hs kept over Sr");
    tx({DEV, 1'b0}, 1'b1);
    tx(8'h05, 1'b1);
    isp_bus_master_inst.stop_c();
    cyc(10);
    chk_bit(hs, 1'b0, "fast after stop");
  endtask

  // Foreign address is refused; without a master code the port stays fast
  task automatic t_other();
    isp_bus_master_inst.start_c();
    tx({7'h2b, 1'b0}, 1'b0);
    tx(8'h05, 1'b0);
    isp_bus_master_inst.stop_c();
    cyc(10);
    chk_bit(hs, 1'b0, "still fast");
    chk_byte(8'(wr_log.size()), 8'h02, "nothing written");
  endtask

  // Forced high speed needs no master code and outlives STOP
  task automatic t_force();
    force_hs = 1'b1;
    cyc(2);
    chk_bit(hs, 1'b1, "forced");
    isp_bus_master_inst.start_c();
    tx({DEV, 1'b1}, 1'b1);
    rx(1'b0, 8'h3c);
    isp_bus_master_inst.stop_c();
    cyc(10);
    chk_bit(hs, 1'b1, "forced after stop");
    force_hs = 1'b0;
    cyc(2);
    chk_bit(hs, 1'b0, "unforced");
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn
  initial begin
    err_total = 0;
    checked = 0;
    rd_cnt = 0;
    i_rst_b = 1'b0;
    scheme = 1'b1;
    adr_pins = ADR;
    force_hs = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1 i_rst_b = 1'b1;
    cyc(12);
    t_reset();
    t_write();
    t_read();
    t_hs(8'h08);
    t_hs(8'h0f);
    t_other();
    t_force();
    t_scheme();
    end_sim();
  end

  // Watchdog: the scenarios need about 17 us of link traffic
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule

`default_nettype wire
